/* pstb_pkg.sv */
// shared constants and types for the status and telemetry command bank
package pstb_pkg;

  // command codes
  localparam logic [7:0] PSTB_CMD_CLEAR_FAULTS        = 8'h03;
  localparam logic [7:0] PSTB_CMD_TEMPERATURE_STATUS  = 8'h7d;
  localparam logic [7:0] PSTB_CMD_COMM_LOGIC_STATUS   = 8'h7e;
  localparam logic [7:0] PSTB_CMD_VENDOR_MON_STATUS   = 8'h80;
  localparam logic [7:0] PSTB_CMD_INPUT_VOLTAGE_READ  = 8'h88;
  localparam logic [7:0] PSTB_CMD_OUTPUT_VOLTAGE_READ = 8'h8b;

  // reset values
  localparam logic [7:0]  PSTB_STATUS_RESET  = 8'h00;
  localparam logic [15:0] PSTB_READING_RESET = 16'h0000;

  // temperature status bits
  localparam int PSTB_TEMP_OT_FAULT_BIT = 7;
  localparam int PSTB_TEMP_OT_WARN_BIT  = 6;
  localparam int PSTB_TEMP_UT_WARN_BIT  = 5;
  localparam int PSTB_TEMP_UT_FAULT_BIT = 4;

  // communication error bits
  localparam int PSTB_CML_BAD_CMD_BIT   = 7;
  localparam int PSTB_CML_BAD_DATA_BIT  = 6;
  localparam int PSTB_CML_PEC_BIT       = 5;
  localparam int PSTB_CML_OTHER_BIT     = 1;

  // vendor monitor bits
  localparam int PSTB_VND_IMB_ERR_BIT   = 6;
  localparam int PSTB_VND_UV_WARN_BIT   = 5;
  localparam int PSTB_VND_OV_WARN_BIT   = 4;
  localparam int PSTB_VND_SYNC_LOST_BIT = 3;
  localparam int PSTB_VND_UV_FAULT_BIT  = 1;
  localparam int PSTB_VND_OV_FAULT_BIT  = 0;

  // status word summary bits
  localparam int PSTB_SW_TEMPERATURE_BIT = 2;
  localparam int PSTB_SW_COMM_BIT        = 1;

  // linear-11 packing and linear-16 scale
  localparam int PSTB_L11_EXP_MSB  = 15;
  localparam int PSTB_L11_EXP_LSB  = 11;
  localparam int PSTB_L11_MANT_MSB = 10;
  localparam int PSTB_L16_EXPONENT = -13;

  // warning margins as ratios of ten
  localparam int PSTB_WARN_DEN      = 10;
  localparam int PSTB_WARN_LOW_NUM  = 9;
  localparam int PSTB_WARN_HIGH_NUM = 11;

  // answer lengths in bytes
  localparam logic [1:0] PSTB_LEN_NONE = 2'h0;
  localparam logic [1:0] PSTB_LEN_BYTE = 2'h1;
  localparam logic [1:0] PSTB_LEN_WORD = 2'h2;

  localparam int PSTB_PAGE_W = 2;

  typedef enum logic [2:0] {
    PSTB_K_UNKNOWN,
    PSTB_K_CLEAR,
    PSTB_K_TEMP,
    PSTB_K_CML,
    PSTB_K_VENDOR,
    PSTB_K_VIN,
    PSTB_K_VOUT
  } pstb_kind_e;

  typedef struct packed {
    logic [7:0]             code;
    logic                   write;
    logic [PSTB_PAGE_W-1:0] page;
    logic                   pec_error;
    logic                   data_error;
  } pstb_cmd_s;

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic ut_warn;
    logic ut_fault;
  } pstb_temp_evt_s;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  len;
    logic        refused;
  } pstb_answer_s;

endpackage : pstb_pkg

/* pstb_monitor_cmp.sv */
// monitor pin voltage threshold comparator
`timescale 1ns/1ps
`default_nettype none
module pstb_monitor_cmp
  import pstb_pkg::*;
#(
  parameter int MON_W = 12
)(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // sample and thresholds
  input  wire logic             sample_valid,
  input  wire logic [MON_W-1:0] voltage,
  input  wire logic [MON_W-1:0] low_threshold,
  input  wire logic [MON_W-1:0] high_threshold,
  // one-cycle detections
  output logic                  uv_fault,
  output logic                  ov_fault,
  output logic                  uv_warn,
  output logic                  ov_warn
);

  localparam int PW = MON_W + 4;

  // scale the voltage by ten and the thresholds by nine and eleven so no divider is needed
  wire logic [PW-1:0] v_scaled    = PW'(voltage) * PW'(PSTB_WARN_DEN);
  wire logic [PW-1:0] low_margin  = PW'(low_threshold) * PW'(PSTB_WARN_LOW_NUM);
  wire logic [PW-1:0] high_margin = PW'(high_threshold) * PW'(PSTB_WARN_HIGH_NUM);

  wire logic uv_fault_next = sample_valid && (voltage < low_threshold);
  wire logic ov_fault_next = sample_valid && (voltage > high_threshold);
  wire logic uv_warn_next  = sample_valid && (v_scaled < low_margin);
  wire logic ov_warn_next  = sample_valid && (v_scaled > high_margin);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      uv_fault <= 1'b0;
      ov_fault <= 1'b0;
      uv_warn  <= 1'b0;
      ov_warn  <= 1'b0;
    end
    else
    begin
      uv_fault <= uv_fault_next;
      ov_fault <= ov_fault_next;
      uv_warn  <= uv_warn_next;
      ov_warn  <= ov_warn_next;
    end
  end

endmodule : pstb_monitor_cmp
`default_nettype wire

/* pstb_bank.sv */
// status and telemetry command bank of the point-of-load converter
// Notes on behaviour
// - paged temperature status byte, cleared after reset
// - bits 7..4: over/under temperature fault, warning
// - global communication error byte, zero after reset
// - bit 7: unknown or unsupported command code
// - bit 6: command with invalid or unsupported data
// - bit 5: packet error detected in command
// - bit 1: write to read-only, other faults
// - global vendor status byte, zero after reset
// - bit 6: inter module bus error
// - bit 5: monitor voltage ten percent under low
// - bit 4: monitor voltage ten percent over high
// - bit 3: external clock synchronisation lost
// - bit 1: monitor voltage below low threshold
// - bit 0: monitor voltage above high threshold
// - global two byte linear-11 input voltage
// - paged unsigned output voltage, scale two^-13
// - status word bit 2 on temperature events
// - status word bit 1 on communication errors
`timescale 1ns/1ps
`default_nettype none
module pstb_bank
  import pstb_pkg::*;
#(
  parameter int PAGES = 2,
  parameter int MON_W = 12
)(
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // command from the bus protocol engine
  input  wire logic                             cmd_valid,
  input  wire pstb_cmd_s                        cmd,
  input  wire logic                             other_comm_fault,
  // answer to the bus protocol engine
  output logic                                  ans_valid,
  output pstb_answer_s                          ans,
  // temperature events per page
  input  wire pstb_temp_evt_s [PAGES-1:0]       temp_evt,
  // vendor monitor sources
  input  wire logic                             monitor_sample_valid,
  input  wire logic [MON_W-1:0]                 monitor_pin_voltage,
  input  wire logic [MON_W-1:0]                 monitor_low_threshold,
  input  wire logic [MON_W-1:0]                 monitor_high_threshold,
  input  wire logic                             inter_module_bus_error,
  input  wire logic                             sync_lost,
  // telemetry samples
  input  wire logic                             vin_valid,
  input  wire logic [4:0]                       vin_exponent,
  input  wire logic [10:0]                      vin_mantissa,
  input  wire logic [PAGES-1:0]                 vout_valid,
  input  wire logic [PAGES-1:0][15:0]           vout_code,
  // status word summary bits
  output logic [PAGES-1:0]                      temp_summary,
  output logic                                  comm_summary
);

  // page field is two bits wide, so at most four pages
  if (PAGES < 1 || PAGES > (1 << PSTB_PAGE_W))
  begin : g_bad_pages
    $error("pstb_bank: PAGES out of range");
  end
  if (MON_W < 2 || MON_W > 24)
  begin : g_bad_mon_w
    $error("pstb_bank: MON_W out of range");
  end

  // command decode
  pstb_kind_e kind;

  always_comb
  begin
    case (cmd.code)
      PSTB_CMD_CLEAR_FAULTS:        kind = PSTB_K_CLEAR;
      PSTB_CMD_TEMPERATURE_STATUS:  kind = PSTB_K_TEMP;
      PSTB_CMD_COMM_LOGIC_STATUS:   kind = PSTB_K_CML;
      PSTB_CMD_VENDOR_MON_STATUS:   kind = PSTB_K_VENDOR;
      PSTB_CMD_INPUT_VOLTAGE_READ:  kind = PSTB_K_VIN;
      PSTB_CMD_OUTPUT_VOLTAGE_READ: kind = PSTB_K_VOUT;
      default:                      kind = PSTB_K_UNKNOWN;
    endcase
  end

  wire logic is_paged   = (kind == PSTB_K_TEMP) || (kind == PSTB_K_VOUT);
  wire logic page_bad   = is_paged && (int'(cmd.page) >= PAGES);
  wire logic is_ro      = (kind != PSTB_K_CLEAR) && (kind != PSTB_K_UNKNOWN);

  // a packet error hides every other check; nothing else about the frame is trusted
  wire logic err_pec    = cmd_valid && cmd.pec_error;
  wire logic err_cmd    = cmd_valid && !cmd.pec_error && (kind == PSTB_K_UNKNOWN);
  wire logic err_write  = cmd_valid && !cmd.pec_error && cmd.write && is_ro;
  // clear is a send-byte; reading it is an unsupported use of the command
  wire logic err_clr_rd = cmd_valid && !cmd.pec_error && !cmd.write && (kind == PSTB_K_CLEAR);
  wire logic err_data   = cmd_valid && !cmd.pec_error && !err_cmd && !err_write
                          && (cmd.data_error || page_bad);
  wire logic refuse     = err_pec || err_cmd || err_write || err_clr_rd || err_data;
  wire logic do_clear   = cmd_valid && !refuse && (kind == PSTB_K_CLEAR);
  wire logic do_read    = cmd_valid && !refuse && !cmd.write && is_ro;

  // temperature status, one byte per page
  logic [PAGES-1:0][7:0] temp_status_reg;

  for (genvar p = 0; p < PAGES; p++)
  begin : g_page
    wire logic [7:0] temp_set;
    wire logic [7:0] temp_next;

    assign temp_set[PSTB_TEMP_OT_FAULT_BIT] = temp_evt[p].ot_fault;
    assign temp_set[PSTB_TEMP_OT_WARN_BIT]  = temp_evt[p].ot_warn;
    assign temp_set[PSTB_TEMP_UT_WARN_BIT]  = temp_evt[p].ut_warn;
    assign temp_set[PSTB_TEMP_UT_FAULT_BIT] = temp_evt[p].ut_fault;
    assign temp_set[3:0]                    = 4'h0;

    // an event in the clearing cycle survives the clear
    assign temp_next = (do_clear ? PSTB_STATUS_RESET : temp_status_reg[p]) | temp_set;

    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        temp_status_reg[p] <= PSTB_STATUS_RESET;
      end
      else
      begin
        temp_status_reg[p] <= temp_next;
      end
    end
  end

  // communication error byte
  logic [7:0]      comm_status_reg;
  wire logic [7:0] comm_set;
  wire logic [7:0] comm_next;

  assign comm_set[PSTB_CML_BAD_CMD_BIT]  = err_cmd || err_clr_rd;
  assign comm_set[PSTB_CML_BAD_DATA_BIT] = err_data;
  assign comm_set[PSTB_CML_PEC_BIT]      = err_pec;
  assign comm_set[4:2]                   = 3'h0;
  assign comm_set[PSTB_CML_OTHER_BIT]    = err_write || other_comm_fault;
  assign comm_set[0]                     = 1'b0;

  assign comm_next = (do_clear ? PSTB_STATUS_RESET : comm_status_reg) | comm_set;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      comm_status_reg <= PSTB_STATUS_RESET;
    end
    else
    begin
      comm_status_reg <= comm_next;
    end
  end

  // vendor monitor byte
  logic mon_uv_fault;
  logic mon_ov_fault;
  logic mon_uv_warn;
  logic mon_ov_warn;

  pstb_monitor_cmp #(
    .MON_W          (MON_W)
  ) u_monitor_cmp (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .sample_valid   (monitor_sample_valid),
    .voltage        (monitor_pin_voltage),
    .low_threshold  (monitor_low_threshold),
    .high_threshold (monitor_high_threshold),
    .uv_fault       (mon_uv_fault),
    .ov_fault       (mon_ov_fault),
    .uv_warn        (mon_uv_warn),
    .ov_warn        (mon_ov_warn)
  );

  logic [7:0]      vendor_status_reg;
  wire logic [7:0] vendor_set;
  wire logic [7:0] vendor_next;

  assign vendor_set[7]                      = 1'b0;
  assign vendor_set[PSTB_VND_IMB_ERR_BIT]   = inter_module_bus_error;
  assign vendor_set[PSTB_VND_UV_WARN_BIT]   = mon_uv_warn;
  assign vendor_set[PSTB_VND_OV_WARN_BIT]   = mon_ov_warn;
  assign vendor_set[PSTB_VND_SYNC_LOST_BIT] = sync_lost;
  assign vendor_set[2]                      = 1'b0;
  assign vendor_set[PSTB_VND_UV_FAULT_BIT]  = mon_uv_fault;
  assign vendor_set[PSTB_VND_OV_FAULT_BIT]  = mon_ov_fault;

  assign vendor_next = (do_clear ? PSTB_STATUS_RESET : vendor_status_reg) | vendor_set;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      vendor_status_reg <= PSTB_STATUS_RESET;
    end
    else
    begin
      vendor_status_reg <= vendor_next;
    end
  end

  // telemetry holding registers
  logic [15:0]            vin_reg;
  logic [PAGES-1:0][15:0] vout_reg;

  wire logic [15:0] vin_packed;
  assign vin_packed[PSTB_L11_EXP_MSB:PSTB_L11_EXP_LSB] = vin_exponent;
  assign vin_packed[PSTB_L11_MANT_MSB:0]               = vin_mantissa;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      vin_reg <= PSTB_READING_RESET;
    end
    else if (vin_valid)
    begin
      vin_reg <= vin_packed;
    end
  end

  // the code is passed through unchanged; the host applies the fixed scale
  for (genvar p = 0; p < PAGES; p++)
  begin : g_vout
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        vout_reg[p] <= PSTB_READING_RESET;
      end
      else if (vout_valid[p])
      begin
        vout_reg[p] <= vout_code[p];
      end
    end
  end

  // answer selection; page is only trusted once checked against PAGES
  wire logic [PSTB_PAGE_W-1:0] sel_page = page_bad ? '0 : cmd.page;

  logic [15:0] rd_word;
  logic [1:0]  rd_len;

  always_comb
  begin
    rd_word = PSTB_READING_RESET;
    rd_len  = PSTB_LEN_NONE;
    case (kind)
      PSTB_K_TEMP:
      begin
        rd_word = {8'h00, temp_status_reg[sel_page]};
        rd_len  = PSTB_LEN_BYTE;
      end
      PSTB_K_CML:
      begin
        rd_word = {8'h00, comm_status_reg};
        rd_len  = PSTB_LEN_BYTE;
      end
      PSTB_K_VENDOR:
      begin
        rd_word = {8'h00, vendor_status_reg};
        rd_len  = PSTB_LEN_BYTE;
      end
      PSTB_K_VIN:
      begin
        rd_word = vin_reg;
        rd_len  = PSTB_LEN_WORD;
      end
      PSTB_K_VOUT:
      begin
        rd_word = vout_reg[sel_page];
        rd_len  = PSTB_LEN_WORD;
      end
      default:
      begin
        rd_word = PSTB_READING_RESET;
        rd_len  = PSTB_LEN_NONE;
      end
    endcase
  end

  pstb_answer_s ans_next;
  assign ans_next.data    = do_read ? rd_word : PSTB_READING_RESET;
  assign ans_next.len     = do_read ? rd_len : PSTB_LEN_NONE;
  assign ans_next.refused = refuse;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ans_valid <= 1'b0;
    end
    else
    begin
      ans_valid <= cmd_valid;
    end
  end

  // answer holds until the next command so a slow reader still sees it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ans <= '0;
    end
    else if (cmd_valid)
    begin
      ans <= ans_next;
    end
  end

  // status word summary bits, one cycle behind the status bytes
  wire logic [PAGES-1:0] temp_any;
  for (genvar p = 0; p < PAGES; p++)
  begin : g_sum
    assign temp_any[p] = |temp_status_reg[p];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      temp_summary <= '0;
    end
    else
    begin
      temp_summary <= temp_any;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      comm_summary <= 1'b0;
    end
    else
    begin
      comm_summary <= |comm_status_reg;
    end
  end

endmodule : pstb_bank
`default_nettype wire

/* pstb_bank_monitor.sv */
// assertion checker for the status and telemetry command bank
`timescale 1ns/1ps
`default_nettype none
module pstb_bank_monitor
  import pstb_pkg::*;
#(
  parameter int PAGES = 2
)(
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst,
  // command and answer
  input wire logic                       cmd_valid,
  input wire pstb_cmd_s                  cmd,
  input wire logic                       other_comm_fault,
  input wire logic                       ans_valid,
  input wire pstb_answer_s               ans,
  // events and summaries
  input wire pstb_temp_evt_s [PAGES-1:0] temp_evt,
  input wire logic [PAGES-1:0]           temp_summary,
  input wire logic                       comm_summary
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic known   = cmd.code inside {8'h03, 8'h7d, 8'h7e, 8'h80, 8'h88, 8'h8b};
  wire logic clean   = cmd_valid && !cmd.pec_error;
  wire logic ro_code = known && cmd.code != 8'h03;
  wire logic rd      = clean && ro_code && !cmd.write && !cmd.data_error;
  // refused answer, then the summary one cycle behind the byte
  sequence comm_flag_s;
    ##1 (ans_valid && ans.refused) ##1 comm_summary;
  endsequence
  sequence word_ans_s;
    ##1 (ans_valid && !ans.refused && ans.len == PSTB_LEN_WORD);
  endsequence
  reset_zero_a: assert property ($fell(rst) |-> !ans_valid && !comm_summary && temp_summary == '0)
    else $error("outputs not clear after reset");
  bad_code_a: assert property (clean && (!known || (cmd.code == 8'h03 && !cmd.write)) |-> comm_flag_s)
    else $error("unknown command not flagged");
  bad_data_a: assert property (clean && ro_code && !cmd.write && cmd.data_error
    |=> ans_valid && ans.refused)
    else $error("bad data not refused");
  pec_refuse_a: assert property (cmd_valid && cmd.pec_error |-> comm_flag_s)
    else $error("packet error not flagged");
  ro_write_a: assert property (clean && ro_code && cmd.write |-> comm_flag_s)
    else $error("write to read-only not flagged");
  other_fault_a: assert property (other_comm_fault |-> ##2 comm_summary)
    else $error("other fault not summarised");
  temp_sum_a: assert property (temp_evt[0] != '0 |-> ##2 temp_summary[0])
    else $error("temperature event not summarised");
  temp_bits_a: assert property (rd && cmd.code == 8'h7d && cmd.page < PAGES
    |=> ans.data[15:8] == 8'h00 && ans.data[3:0] == 4'h0)
    else $error("temperature unused bits set");
  cml_bits_a: assert property (rd && cmd.code == 8'h7e
    |=> ans.data[15:8] == 8'h00 && ans.data[4:2] == 3'h0 && !ans.data[0])
    else $error("comm unused bits set");
  vnd_bits_a: assert property (rd && cmd.code == 8'h80
    |=> ans.data[15:8] == 8'h00 && !ans.data[7] && !ans.data[2])
    else $error("vendor unused bits set");
  vin_word_a: assert property (rd && cmd.code == 8'h88 |-> word_ans_s)
    else $error("input voltage not a word");
  vout_word_a: assert property (rd && cmd.code == 8'h8b && cmd.page < PAGES |-> word_ans_s)
    else $error("output voltage not a word");
endmodule : pstb_bank_monitor
bind pstb_bank pstb_bank_monitor #(.PAGES(PAGES)) i_pstb_bank_monitor (.sys_clk(sys_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .other_comm_fault(other_comm_fault), .ans_valid(ans_valid), .ans(ans),
  .temp_evt(temp_evt), .temp_summary(temp_summary), .comm_summary(comm_summary));
`default_nettype wire

/* pstb_host.sv */
// host controller model that issues commands and watches the answers
`timescale 1ns/1ps
`default_nettype none
module pstb_host
  import pstb_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // request from the bench
  input  wire logic         req,
  input  wire pstb_cmd_s    req_cmd,
  // command bus to the bank
  output logic              cmd_valid,
  output pstb_cmd_s         cmd,
  // answer from the bank
  input  wire logic         ans_valid,
  input  wire pstb_answer_s ans,
  // sticky protocol error
  output logic              host_err
);
  logic pend_reg;
  logic wr_reg;
  logic err_next;
  assign cmd_valid = req;
  // idle bus shows the inverse so a stale command never looks live
  assign cmd = req ? req_cmd : ~req_cmd;
  // a write to a read-only command must come back refused
  assign err_next = host_err || ans_valid != pend_reg || (wr_reg && ans_valid && !ans.refused);
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_reg <= 1'b0;
      wr_reg   <= 1'b0;
      host_err <= 1'b0;
    end
    else
    begin
      pend_reg <= req;
      wr_reg   <= req && req_cmd.write && req_cmd.code != PSTB_CMD_CLEAR_FAULTS;
      host_err <= err_next;
    end
  end
endmodule : pstb_host
`default_nettype wire

/* tb_pstb_bank.sv */
// self-checking bench for the status and telemetry command bank
`timescale 1ns/1ps
`default_nettype none
module tb_pstb_bank
  import pstb_pkg::*;
;
  localparam int PAGES = 2;
  logic                       sys_clk = 0;
  logic                       rst = 1;
  logic                       req = 0;
  pstb_cmd_s                  req_cmd = '0;
  logic                       cmd_valid, ans_valid, comm_summary, host_err;
  pstb_cmd_s                  cmd;
  pstb_answer_s               ans;
  logic [PAGES-1:0]           temp_summary;
  logic                       other_comm_fault = 0, mon_valid = 0, imb_err = 0, sync_lost = 0, vin_valid = 0;
  logic [11:0]                mon_v = 0, mon_lo = 0, mon_hi = 0;
  logic [4:0]                 vin_exp = 0;
  logic [10:0]                vin_mant = 0;
  logic [PAGES-1:0]           vout_valid = '0;
  logic [PAGES-1:0][15:0]     vout_code = '0;
  pstb_temp_evt_s [PAGES-1:0] temp_evt = '0;
  logic [31:0]                seed = 32'hd6cc;
  logic [7:0]                 codes[5] = '{8'h7d, 8'h7e, 8'h80, 8'h88, 8'h8b};
  int                         fail_count = 0, comparisons = 0;
  int                         m_temp[PAGES], m_vout[PAGES], m_cml, m_vnd, m_vin;
  pstb_answer_s               exp_q[$];

  pstb_host i_pstb_host (.sys_clk(sys_clk), .rst(rst), .req(req), .req_cmd(req_cmd), .cmd_valid(cmd_valid),
    .cmd(cmd), .ans_valid(ans_valid), .ans(ans), .host_err(host_err));
  pstb_bank #(.PAGES(PAGES), .MON_W(12)) i_pstb_bank (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .other_comm_fault(other_comm_fault), .ans_valid(ans_valid), .ans(ans), .temp_evt(temp_evt),
    .monitor_sample_valid(mon_valid), .monitor_pin_voltage(mon_v), .monitor_low_threshold(mon_lo),
    .monitor_high_threshold(mon_hi), .inter_module_bus_error(imb_err), .sync_lost(sync_lost),
    .vin_valid(vin_valid), .vin_exponent(vin_exp), .vin_mantissa(vin_mant), .vout_valid(vout_valid),
    .vout_code(vout_code), .temp_summary(temp_summary), .comm_summary(comm_summary));

  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // model works out the answer; requests stay up back to back
  task automatic send(input logic [7:0] c, input logic w, input logic [1:0] p, input logic pe, input logic de);
    pstb_answer_s e;
    logic [7:0]   mb;
    e = '0;
    mb = 8'h00;
    if (pe) mb = 8'h20;
    else if (!(c inside {8'h03, 8'h7d, 8'h7e, 8'h80, 8'h88, 8'h8b}) || (c == 8'h03 && !w)) mb = 8'h80;
    else if (w && c != 8'h03) mb = 8'h02;
    else if (de || (c inside {8'h7d, 8'h8b} && p >= PAGES)) mb = 8'h40;
    else if (c == 8'h03)
    begin
      m_temp = '{default: 0};
      m_cml = 0;
      m_vnd = 0;
    end
    else
    begin
      e.len = (c inside {8'h88, 8'h8b}) ? PSTB_LEN_WORD : PSTB_LEN_BYTE;
      case (c)
        8'h7d: e.data = 16'(m_temp[p]);
        8'h7e: e.data = 16'(m_cml);
        8'h80: e.data = 16'(m_vnd);
        8'h88: e.data = 16'(m_vin);
        default: e.data = 16'(m_vout[p]);
      endcase
    end
    e.refused = mb != 8'h00;
    m_cml |= mb;
    exp_q.push_back(e);
    @(posedge sys_clk);
    #1;
    req = 1;
    req_cmd = '{c, w, p, pe, de};
  endtask : send

  // one cycle of random events on every source, then settle and check summaries
  task automatic evt();
    int p, v, lo, hi;
    @(posedge sys_clk);
    #1;
    req = 0;
    vout_valid = PAGES'(rnd());
    for (p = 0; p < PAGES; p++)
    begin
      temp_evt[p] = 4'(rnd() & rnd());
      vout_code[p] = 16'(rnd());
      m_temp[p] |= {temp_evt[p], 4'h0};
      if (vout_valid[p]) m_vout[p] = vout_code[p];
    end
    {imb_err, sync_lost, other_comm_fault} = 3'(rnd() & rnd());
    {mon_v, mon_lo, mon_hi} = 36'({rnd(), rnd()});
    {vin_exp, vin_mant} = 16'(rnd());
    mon_valid = 1;
    vin_valid = 1;
    v = mon_v;
    lo = mon_lo;
    hi = mon_hi;
    m_vin = {vin_exp, vin_mant};
    m_vnd |= {1'b0, imb_err, 10 * v < 9 * lo, 10 * v > 11 * hi, sync_lost, 1'b0, v < lo, v > hi};
    m_cml |= {other_comm_fault, 1'b0};
    @(posedge sys_clk);
    #1;
    temp_evt = '0;
    {imb_err, sync_lost, other_comm_fault, mon_valid, vin_valid} = 5'h00;
    vout_valid = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    for (p = 0; p < PAGES; p++) check("temp_summary", temp_summary[p], m_temp[p] != 0);
    check("comm_summary", comm_summary, m_cml != 0);
  endtask : evt

  always @(posedge sys_clk)
    if (ans_valid === 1'b1)
    begin
      if (exp_q.size() == 0) check("answer count", 1, 0);
      else check("answer", 32'(ans), 32'(exp_q.pop_front()));
    end

  task automatic stop_test();
    if (exp_q.size() != 0 || host_err !== 1'b0) fail_count++;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #80000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 0;
    foreach (codes[i]) send(codes[i], 0, 0, 0, 0);
    evt();
    $display("test reset done");
    repeat (30)
    begin
      foreach (codes[i]) send(codes[i], 0, 2'(rnd()), 0, 0);
      evt();
    end
    $display("test events done");
    for (int i = 0; i < 6; i++)
    begin
      send(8'h03, 1, 0, 0, 0);
      case (i)
        0: send(8'h5a, 0, 0, 0, 0);
        1: send(8'h03, 0, 0, 0, 0);
        2: send(8'h88, 1, 0, 0, 0);
        3: send(8'h7e, 0, 0, 1, 0);
        4: send(8'h80, 0, 0, 0, 1);
        default: send(8'h7d, 0, 3, 0, 0);
      endcase
      send(8'h7e, 0, 0, 0, 0);
    end
    foreach (codes[i]) send(codes[i], 0, 1, 0, 0);
    evt();
    $display("test errors done");
    stop_test();
  end
endmodule : tb_pstb_bank
`default_nettype wire
